// ### src/bcr_top.sv
// bcr_top: preset entry, symbol filtering and counting, reader modes
// Contract
// R1: unescaped ! or ? becomes wildcard marker
// R2: backslash escapes !, ? or backslash literally
// R3: refuse preset codes 00h-2Fh, never compare
// R4: start/stop and check excluded from count; BCR_SYM_OTHER counts them
// R5: CODE128 function, shift, set selectors uncounted
// R6: CODE128 digits 1-32 for A/B, 2-64 C
// R7: one A/B character equals two C digits
// R8: start/stop and check never sent to host; BCR_SYM_OTHER sends them
// R9: CODE128 function, shift, selectors never sent
// R10: decoded control characters are sent
// R11: avoid CODE93 control characters on multidrop
// R12: halt stops laser, flashes bottom LED
// R13: 8 s switch hold enters settings transfer
// R14: read rate is decodes per 10 scans
// R15: preset at most 32 (A/B) or 64 (C)
// R16: backslash before other character is rejected
`timescale 1ns/1ps
`include "bcr_params.svh"
module bcr_top #(
  parameter int unsigned HOLD_CYC  = `BCR_HOLD_CYC,
  parameter int unsigned BLINK_CYC = `BCR_BLINK_CYC
) (
  input  logic                    core_clk,
  input  logic                    rst,
  input  bcr_pkg::bcr_cfg_t       cfg,
  input  logic                    preset_valid,
  input  logic [7:0]              preset_data,
  input  logic                    preset_last,
  output logic                    preset_done,
  output logic                    preset_ok,
  input  logic                    sym_valid,
  input  bcr_pkg::bcr_sym_char_t  sym,
  output logic                    sym_ready,
  output logic                    tx_valid,
  output bcr_pkg::bcr_tx_t        tx,
  input  logic                    tx_ready,
  output logic                    res_valid,
  output logic                    res_len_ok,
  output logic                    res_match,
  output logic                    cfg_err,
  input  logic                    halt_cmd,
  input  logic                    resume_cmd,
  input  logic                    test_sw,
  input  logic                    xfer_done,
  output logic                    laser_en,
  output logic [`BCR_LED_NUM-1:0] signal_quality_leds,
  output logic                    xfer_wait,
  output bcr_pkg::bcr_link_cfg_t  link_cfg,
  input  logic                    scan_end,
  input  logic                    decode_ok,
  output logic                    rate_valid,
  output logic [3:0]              rate
);

  // preset entry
  logic                     ent_valid, ent_err, str_end;
  bcr_pkg::bcr_preset_ent_t ent;
  bcr_pkg::bcr_preset_ent_t preset_mem [0:63];
  logic [6:0]               wr_idx_r, wr_idx_nxt;
  logic [6:0]               p_len_r, p_len_nxt;
  logic                     p_err_r, p_err_nxt;
  logic                     preset_ok_r, preset_ok_nxt;
  logic                     preset_done_r, preset_done_nxt;
  logic                     mem_we;
  logic [6:0]               p_limit;
  logic                     err_now;

  bcr_preset_parse u_parse (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (preset_valid),
    .in_data   (preset_data),
    .in_last   (preset_last),
    .ent_valid (ent_valid),
    .ent       (ent),
    .ent_err   (ent_err),
    .str_end   (str_end)
  );

  always_comb begin
    p_limit = (cfg.start_cs == bcr_pkg::BCR_CS_C) ? `BCR_PRESET_C_MAX
                                                   : `BCR_PRESET_AB_MAX; // R15
    mem_we          = 1'b0;
    err_now         = ent_err;
    wr_idx_nxt      = wr_idx_r;
    p_len_nxt       = p_len_r;
    p_err_nxt       = p_err_r;
    preset_ok_nxt   = preset_ok_r;
    preset_done_nxt = 1'b0;
    if (ent_valid) begin
      if (wr_idx_r >= p_limit) begin
        err_now = 1'b1; // R15
      end else begin
        mem_we     = 1'b1;
        wr_idx_nxt = wr_idx_r + 7'h01;
      end
    end
    if (err_now) begin
      p_err_nxt = 1'b1; // R3
    end
    if (str_end) begin
      // a refused string leaves no usable preset behind
      preset_ok_nxt   = ~p_err_nxt & (wr_idx_nxt != 7'h00); // R3
      p_len_nxt       = wr_idx_nxt;
      preset_done_nxt = 1'b1;
      wr_idx_nxt      = 7'h00;
      p_err_nxt       = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      preset_mem[wr_idx_r[5:0]] <= ent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_idx_r      <= 7'h00;
      p_len_r       <= 7'h00;
      p_err_r       <= 1'b0;
      preset_ok_r   <= 1'b0;
      preset_done_r <= 1'b0;
    end else begin
      wr_idx_r      <= wr_idx_nxt;
      p_len_r       <= p_len_nxt;
      p_err_r       <= p_err_nxt;
      preset_ok_r   <= preset_ok_nxt;
      preset_done_r <= preset_done_nxt;
    end
  end

  // decoded symbol stream
  logic                     buf_ready, buf_push;
  bcr_pkg::bcr_tx_t         buf_word;
  logic                     sym_fire, is128, counted, range_ok, hit;
  logic [7:0]               weight, target;
  bcr_pkg::bcr_preset_ent_t cur;
  logic [7:0]               cnt_r, cnt_nxt;
  logic [6:0]               pos_r, pos_nxt;
  logic                     mis_r, mis_nxt;
  logic                     res_valid_r, res_valid_nxt;
  logic                     res_len_ok_r, res_len_ok_nxt;
  logic                     res_match_r, res_match_nxt;
  logic                     cfg_err_r, cfg_err_nxt;

  always_comb begin
    sym_fire = sym_valid & buf_ready;
    is128    = (cfg.symb == bcr_pkg::BCR_SYM_C128);
    // other symbologies count and send every char
    counted  = (cfg.symb == bcr_pkg::BCR_SYM_OTHER) ||
               (sym.kind == bcr_pkg::BCR_SC_DATA); // R4 R5 R8 R9 R10
    // count in set-C digit units: a CODE128 A/B character weighs two
    weight   = (is128 && sym.cset != bcr_pkg::BCR_CS_C) ? 8'h02 : 8'h01; // R7
    target   = (is128 && cfg.start_cs != bcr_pkg::BCR_CS_C) ? {cfg.digits, 1'b0}
                                                             : {1'b0, cfg.digits}; // R7
    if (!is128) begin
      range_ok = 1'b1;
    end else if (cfg.start_cs == bcr_pkg::BCR_CS_C) begin
      range_ok = (cfg.digits >= `BCR_DIG_C_MIN) && (cfg.digits <= `BCR_DIG_C_MAX); // R6
    end else begin
      range_ok = (cfg.digits >= `BCR_DIG_AB_MIN) && (cfg.digits <= `BCR_DIG_AB_MAX); // R6
    end
    cur      = preset_mem[pos_r[5:0]];
    hit      = cur.wild | (cur.data == sym.data); // R1
    cnt_nxt        = cnt_r;
    pos_nxt        = pos_r;
    mis_nxt        = mis_r;
    res_valid_nxt  = 1'b0;
    res_len_ok_nxt = res_len_ok_r;
    res_match_nxt  = res_match_r;
    cfg_err_nxt    = ~range_ok; // R6
    buf_push       = 1'b0;
    buf_word       = '0;
    if (sym_fire) begin
      if (counted) begin
        if (cnt_r < 8'hFE) begin
          cnt_nxt = cnt_r + weight; // R4 R5
        end
        if (pos_r >= p_len_r || !hit) begin
          mis_nxt = 1'b1;
        end
        if (pos_r != 7'h7F) begin
          pos_nxt = pos_r + 7'h01;
        end
      end
      // a dropped last character still closes the message with an empty word
      buf_push      = counted | sym.last; // R8 R9
      buf_word.dv   = counted; // R10
      buf_word.data = sym.data;
      buf_word.last = sym.last;
      if (sym.last) begin
        res_valid_nxt  = 1'b1;
        res_len_ok_nxt = range_ok & (cnt_nxt == target); // R6 R7
        res_match_nxt  = preset_ok_r & ~mis_nxt & (pos_nxt == p_len_r);
        cnt_nxt        = 8'h00;
        pos_nxt        = 7'h00;
        mis_nxt        = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r        <= 8'h00;
      pos_r        <= 7'h00;
      mis_r        <= 1'b0;
      res_valid_r  <= 1'b0;
      res_len_ok_r <= 1'b0;
      res_match_r  <= 1'b0;
      cfg_err_r    <= 1'b0;
    end else begin
      cnt_r        <= cnt_nxt;
      pos_r        <= pos_nxt;
      mis_r        <= mis_nxt;
      res_valid_r  <= res_valid_nxt;
      res_len_ok_r <= res_len_ok_nxt;
      res_match_r  <= res_match_nxt;
      cfg_err_r    <= cfg_err_nxt;
    end
  end

  // a stalled host costs no word
  bcr_buf2 #(
    .W ($bits(bcr_pkg::bcr_tx_t))
  ) u_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (buf_push),
    .in_data   (buf_word),
    .in_ready  (buf_ready),
    .out_valid (tx_valid),
    .out_data  (tx),
    .out_ready (tx_ready)
  );

  // reader modes
  bcr_pkg::bcr_mode_t     mode_r, mode_nxt;
  logic [31:0]            hold_cnt_r, hold_cnt_nxt;
  logic [31:0]            blink_cnt_r, blink_cnt_nxt;
  logic                   blink_r, blink_nxt;
  logic [`BCR_LED_NUM-1:0] leds_r, leds_nxt;
  logic                   laser_en_r, laser_en_nxt;
  logic                   xfer_wait_r, xfer_wait_nxt;
  bcr_pkg::bcr_link_cfg_t link_cfg_r;

  always_comb begin
    mode_nxt      = mode_r;
    hold_cnt_nxt  = 32'h0000_0000;
    blink_cnt_nxt = blink_cnt_r + 32'h0000_0001;
    blink_nxt     = blink_r;
    if (blink_cnt_r >= BLINK_CYC - 1) begin
      blink_cnt_nxt = 32'h0000_0000;
      blink_nxt     = ~blink_r;
    end
    if (test_sw) begin
      hold_cnt_nxt = (hold_cnt_r >= HOLD_CYC) ? hold_cnt_r : hold_cnt_r + 32'h0000_0001;
    end
    unique case (mode_r)
      bcr_pkg::BCR_MODE_RUN: begin
        if (halt_cmd) begin
          mode_nxt = bcr_pkg::BCR_MODE_HALT; // R12
        end else if (test_sw && hold_cnt_r == HOLD_CYC - 1) begin
          mode_nxt = bcr_pkg::BCR_MODE_XFER; // R13
        end
      end
      bcr_pkg::BCR_MODE_HALT: begin
        if (resume_cmd) begin
          mode_nxt = bcr_pkg::BCR_MODE_RUN; // R12
        end
      end
      bcr_pkg::BCR_MODE_XFER: begin
        if (xfer_done) begin
          mode_nxt = bcr_pkg::BCR_MODE_RUN;
        end
      end
      default: begin
        mode_nxt = bcr_pkg::BCR_MODE_RUN;
      end
    endcase
    laser_en_nxt  = (mode_nxt != bcr_pkg::BCR_MODE_HALT); // R12
    xfer_wait_nxt = (mode_nxt == bcr_pkg::BCR_MODE_XFER); // R13
    leds_nxt      = '0;
    if (mode_nxt == bcr_pkg::BCR_MODE_HALT && blink_nxt) begin
      leds_nxt = `BCR_LED_HALT; // R12
    end
    if (mode_nxt == bcr_pkg::BCR_MODE_XFER && blink_nxt) begin
      leds_nxt = `BCR_LED_XFER; // R13
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_r      <= bcr_pkg::BCR_MODE_RUN;
      hold_cnt_r  <= 32'h0000_0000;
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= 1'b0;
      leds_r      <= '0;
      laser_en_r  <= 1'b1;
      xfer_wait_r <= 1'b0;
      link_cfg_r  <= '0;
    end else begin
      mode_r      <= mode_nxt;
      hold_cnt_r  <= hold_cnt_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_r     <= blink_nxt;
      leds_r      <= leds_nxt;
      laser_en_r  <= laser_en_nxt;
      xfer_wait_r <= xfer_wait_nxt;
      link_cfg_r  <= '{baud_div: `BCR_BAUD_DIV, data_bits: `BCR_DATA_BITS,
                       parity_even: 1'b1, stop_bits: `BCR_STOP_BITS}; // R13
    end
  end

  // read rate
  logic [3:0] scan_cnt_r, scan_cnt_nxt;
  logic [3:0] dec_cnt_r, dec_cnt_nxt;
  logic [3:0] rate_r, rate_nxt;
  logic       rate_valid_r, rate_valid_nxt;
  logic [3:0] dec_sum;

  always_comb begin
    dec_sum        = (decode_ok && dec_cnt_r < `BCR_RATE_SCANS) ? dec_cnt_r + 4'h1
                                                                 : dec_cnt_r;
    dec_cnt_nxt    = dec_sum;
    scan_cnt_nxt   = scan_cnt_r;
    rate_nxt       = rate_r;
    rate_valid_nxt = 1'b0;
    if (scan_end) begin
      scan_cnt_nxt = scan_cnt_r + 4'h1;
      if (scan_cnt_r == `BCR_RATE_SCANS - 4'h1) begin
        rate_nxt       = dec_sum; // R14
        rate_valid_nxt = 1'b1;
        scan_cnt_nxt   = 4'h0;
        dec_cnt_nxt    = 4'h0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scan_cnt_r   <= 4'h0;
      dec_cnt_r    <= 4'h0;
      rate_r       <= 4'h0;
      rate_valid_r <= 1'b0;
    end else begin
      scan_cnt_r   <= scan_cnt_nxt;
      dec_cnt_r    <= dec_cnt_nxt;
      rate_r       <= rate_nxt;
      rate_valid_r <= rate_valid_nxt;
    end
  end

  assign preset_done         = preset_done_r;
  assign preset_ok           = preset_ok_r;
  assign sym_ready           = buf_ready;
  assign res_valid           = res_valid_r;
  assign res_len_ok          = res_len_ok_r;
  assign res_match           = res_match_r;
  assign cfg_err             = cfg_err_r;
  assign laser_en            = laser_en_r;
  assign signal_quality_leds = leds_r;
  assign xfer_wait           = xfer_wait_r;
  assign link_cfg            = link_cfg_r;
  assign rate_valid          = rate_valid_r;
  assign rate                = rate_r;

endmodule : bcr_top

// ### src/bcr_params.svh
// bcr_params.svh: reader block constants
`ifndef BCR_PARAMS_SVH
`define BCR_PARAMS_SVH

`define BCR_CLK_KHZ        20000
`define BCR_HOLD_MS        8000
`define BCR_HOLD_CYC       (`BCR_HOLD_MS * `BCR_CLK_KHZ)
`define BCR_BLINK_MS       250
`define BCR_BLINK_CYC      (`BCR_BLINK_MS * `BCR_CLK_KHZ)
`define BCR_BAUD           9600
`define BCR_BAUD_DIV       12'((`BCR_CLK_KHZ * 1000) / `BCR_BAUD)
`define BCR_DATA_BITS      4'h7
`define BCR_STOP_BITS      2'h1

`define BCR_CTRL_MAX       8'h2F
`define BCR_CH_BANG        8'h21
`define BCR_CH_QUEST       8'h3F
`define BCR_CH_BSLASH      8'h5C

`define BCR_PRESET_AB_MAX  7'h20
`define BCR_PRESET_C_MAX   7'h40
`define BCR_DIG_AB_MIN     7'h01
`define BCR_DIG_AB_MAX     7'h20
`define BCR_DIG_C_MIN      7'h02
`define BCR_DIG_C_MAX      7'h40

`define BCR_RATE_SCANS     4'hA
`define BCR_LED_NUM        5
`define BCR_LED_HALT       5'h10
`define BCR_LED_XFER       5'h15

`endif

// ### src/bcr_pkg.sv
// bcr_pkg: reader block types
package bcr_pkg;

  typedef enum logic [1:0] {BCR_SYM_OTHER, BCR_SYM_C93, BCR_SYM_C128} bcr_symb_t;

  typedef enum logic [1:0] {BCR_CS_A, BCR_CS_B, BCR_CS_C} bcr_cset_t;

  typedef enum logic [2:0] {
    BCR_SC_DATA,
    BCR_SC_STARTSTOP,
    BCR_SC_CHECK,
    BCR_SC_FUNC,
    BCR_SC_SHIFT,
    BCR_SC_CODESEL
  } bcr_kind_t;

  typedef enum logic [1:0] {BCR_MODE_RUN, BCR_MODE_HALT, BCR_MODE_XFER} bcr_mode_t;

  typedef struct packed {
    bcr_kind_t  kind;
    bcr_cset_t  cset;
    logic [7:0] data;
    logic       last;
  } bcr_sym_char_t;

  typedef struct packed {
    logic       dv;
    logic [7:0] data;
    logic       last;
  } bcr_tx_t;

  typedef struct packed {
    logic       wild;
    logic [7:0] data;
  } bcr_preset_ent_t;

  typedef struct packed {
    bcr_symb_t  symb;
    bcr_cset_t  start_cs;
    logic [6:0] digits;
  } bcr_cfg_t;

  typedef struct packed {
    logic [11:0] baud_div;
    logic [3:0]  data_bits;
    logic        parity_even;
    logic [1:0]  stop_bits;
  } bcr_link_cfg_t;

endpackage : bcr_pkg

// ### src/bcr_buf2.sv
// bcr_buf2: two-entry valid/ready buffer
`timescale 1ns/1ps
module bcr_buf2 #(
  parameter int W = 10
) (
  input  logic         core_clk,
  input  logic         rst,
  input  logic         in_valid,
  input  logic [W-1:0] in_data,
  output logic         in_ready,
  output logic         out_valid,
  output logic [W-1:0] out_data,
  input  logic         out_ready
);

  logic [W-1:0] head_r, head_nxt, skid_r, skid_nxt;
  logic         head_v_r, head_v_nxt, skid_v_r, skid_v_nxt;
  logic         accept;

  // ready uses only the skid slot: no path from out_ready
  always_comb begin
    accept     = in_valid & ~skid_v_r;
    head_nxt   = head_r;
    head_v_nxt = head_v_r;
    skid_nxt   = skid_r;
    skid_v_nxt = skid_v_r;
    if (head_v_r && out_ready) begin
      head_v_nxt = 1'b0;
    end
    if (!head_v_nxt && skid_v_r) begin
      head_nxt   = skid_r;
      head_v_nxt = 1'b1;
      skid_v_nxt = 1'b0;
    end
    if (accept) begin
      if (!head_v_nxt) begin
        head_nxt   = in_data;
        head_v_nxt = 1'b1;
      end else begin
        skid_nxt   = in_data;
        skid_v_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      head_r   <= '0;
      skid_r   <= '0;
      head_v_r <= 1'b0;
      skid_v_r <= 1'b0;
    end else begin
      head_r   <= head_nxt;
      skid_r   <= skid_nxt;
      head_v_r <= head_v_nxt;
      skid_v_r <= skid_v_nxt;
    end
  end

  assign in_ready  = ~skid_v_r;
  assign out_valid = head_v_r;
  assign out_data  = head_r;

endmodule : bcr_buf2

// ### src/bcr_preset_parse.sv
// bcr_preset_parse: escape and wildcard resolution
`timescale 1ns/1ps
`include "bcr_params.svh"
module bcr_preset_parse (
  input  logic                     core_clk,
  input  logic                     rst,
  input  logic                     in_valid,
  input  logic [7:0]               in_data,
  input  logic                     in_last,
  output logic                     ent_valid,
  output bcr_pkg::bcr_preset_ent_t ent,
  output logic                     ent_err,
  output logic                     str_end
);

  logic esc_r, esc_nxt;
  logic is_special;

  always_comb begin
    is_special = (in_data == `BCR_CH_BANG) || (in_data == `BCR_CH_QUEST);
    esc_nxt    = esc_r;
    ent_valid  = 1'b0;
    ent        = '0;
    ent_err    = 1'b0;
    str_end    = in_valid & in_last;
    if (in_valid) begin
      if (esc_r) begin
        esc_nxt = 1'b0;
        if (is_special || in_data == `BCR_CH_BSLASH) begin
          ent_valid = 1'b1; // R2
          ent.data  = in_data; // R2
        end else begin
          ent_err = 1'b1; // R16
        end
      end else if (in_data == `BCR_CH_BSLASH) begin
        esc_nxt = 1'b1;
        // a trailing escape is malformed
        ent_err = in_last; // R16
      end else if (is_special) begin
        ent_valid = 1'b1;
        ent.wild  = 1'b1; // R1
        ent.data  = in_data;
      end else if (in_data <= `BCR_CTRL_MAX) begin
        ent_err = 1'b1; // R3
      end else begin
        ent_valid = 1'b1;
        ent.data  = in_data;
      end
      if (in_last) begin
        esc_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      esc_r <= 1'b0;
    end else begin
      esc_r <= esc_nxt;
    end
  end

endmodule : bcr_preset_parse

// ### sim/bcr_top_chk.sv
// bcr_top_chk: port assertions for the reader block
`timescale 1ns/1ps
module bcr_top_chk (
  input logic                   core_clk,
  input logic                   rst,
  input bcr_pkg::bcr_cfg_t      cfg,
  input logic                   preset_valid,
  input logic                   preset_last,
  input logic                   preset_done,
  input logic                   sym_valid,
  input bcr_pkg::bcr_sym_char_t sym,
  input logic                   sym_ready,
  input logic                   tx_valid,
  input bcr_pkg::bcr_tx_t       tx,
  input logic                   tx_ready,
  input logic                   res_valid,
  input logic                   cfg_err,
  input logic                   halt_cmd,
  input logic                   resume_cmd,
  input logic                   laser_en,
  input logic [4:0]             signal_quality_leds,
  input logic                   xfer_wait,
  input bcr_pkg::bcr_link_cfg_t link_cfg,
  input logic                   rate_valid,
  input logic [3:0]             rate
);
  logic dig_bad;
  // the legal digit range hangs on the starting code set
  assign dig_bad = cfg.symb == bcr_pkg::BCR_SYM_C128 && (cfg.start_cs == bcr_pkg::BCR_CS_C ?
    (cfg.digits < 7'h02 || cfg.digits > 7'h40) : (cfg.digits < 7'h01 || cfg.digits > 7'h20));
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_done_after_last: assert property (preset_valid && preset_last |=> preset_done)
    else $error("no done");
  chk_res_after_last: assert property (sym_valid && sym_ready && sym.last |=> res_valid)
    else $error("no result");
  chk_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx))
    else $error("tx moved");
  chk_halt_stops: assert property (halt_cmd && !resume_cmd && !xfer_wait |=> !laser_en)
    else $error("laser on");
  chk_resume_runs: assert property (resume_cmd && !halt_cmd && !laser_en && !xfer_wait
    |=> laser_en)
    else $error("laser off");
  chk_halt_leds: assert property (!laser_en && !xfer_wait |-> signal_quality_leds[3:0] == 4'h0)
    else $error("halt leds");
  chk_xfer_link: assert property (xfer_wait |-> link_cfg == 19'h411BD)
    else $error("link cfg");
  chk_xfer_leds: assert property (xfer_wait |-> !signal_quality_leds[1] && !signal_quality_leds[3]
    && signal_quality_leds[0] == signal_quality_leds[4])
    else $error("xfer leds");
  chk_rate_bound: assert property (rate_valid |-> rate <= 4'hA)
    else $error("rate high");
  chk_cfg_range: assert property (1'b1 |=> cfg_err == $past(dig_bad))
    else $error("cfg_err");
endmodule : bcr_top_chk

bind bcr_top bcr_top_chk i_bcr_top_chk (.*);

// ### sim/bcr_host_model.sv
// bcr_host_model: stallable host sink
`timescale 1ns/1ps
module bcr_host_model (
  input  logic             core_clk,
  input  logic             rst,
  input  logic             stall,
  input  logic             tx_valid,
  input  bcr_pkg::bcr_tx_t tx,
  output logic             tx_ready
);
  bcr_pkg::bcr_tx_t got[$];
  // stall only withholds ready
  assign tx_ready = !stall;
  // point-to-point, control chars safe
  always @(posedge core_clk)
    if (!rst && tx_valid && tx_ready) got.push_back(tx);
endmodule : bcr_host_model

// ### sim/test_bcr_top.sv
// test_bcr_top: self-checking reader bench
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module test_bcr_top;
  logic core_clk, rst, preset_valid, preset_last, preset_done, preset_ok, sym_valid, sym_ready;
  logic tx_valid, tx_ready, res_valid, res_len_ok, res_match, cfg_err, halt_cmd, resume_cmd;
  logic test_sw, xfer_done, laser_en, xfer_wait, scan_end, decode_ok, rate_valid, stall;
  logic [7:0]             preset_data;
  logic [4:0]             signal_quality_leds;
  logic [3:0]             rate, rv_rate;
  bcr_pkg::bcr_cfg_t      cfg;
  bcr_pkg::bcr_sym_char_t sym;
  bcr_pkg::bcr_tx_t       tx;
  bcr_pkg::bcr_link_cfg_t link_cfg;
  bcr_pkg::bcr_cset_t     cs;
  int                     err_total, compares, cyc, rv_n;

  bcr_top #(.HOLD_CYC(50), .BLINK_CYC(4)) i_bcr_top (.*);
  bcr_host_model i_bcr_host_model (.*);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (rate_valid === 1'b1) begin
      rv_n++;
      rv_rate = rate;
    end
    if (cyc == 8000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic send_preset(input string s, input logic ok_e);
    for (int i = 0; i < s.len(); i++) begin
      #5;
      preset_valid = 1'b1;
      preset_data = s[i];
      preset_last = i == s.len() - 1;
      @(posedge core_clk);
    end
    #5;
    preset_valid = 1'b0;
    `CHK(preset_done, 1'b1)
    `CHK(preset_ok, ok_e)
    @(posedge core_clk);
  endtask : send_preset

  task automatic send_sym(input bcr_pkg::bcr_kind_t k, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    #5;
    sym_valid = 1'b1;
    sym = '{k, cs, d, l};
    while (sym_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #5;
      n++;
    end
    @(posedge core_clk);
  endtask : send_sym

  task automatic chk_tx(input bcr_pkg::bcr_tx_t e[$]);
    bcr_pkg::bcr_tx_t g[$];
    repeat (8) @(posedge core_clk);
    g = i_bcr_host_model.got;
    `CHK(g.size(), e.size())
    foreach (e[i]) begin
      if (i < g.size()) begin
        `CHK({g[i].dv, g[i].last}, {e[i].dv, e[i].last})
        if (e[i].dv) `CHK(g[i].data, e[i].data)
      end
    end
    i_bcr_host_model.got.delete();
  endtask : chk_tx

  // framing and selectors wrap the data
  task automatic frame(input string d, input logic len_e, input logic match_e);
    bcr_pkg::bcr_tx_t e[$];
    logic c128;
    c128 = cfg.symb == bcr_pkg::BCR_SYM_C128;
    send_sym(bcr_pkg::BCR_SC_STARTSTOP, 8'h00, 1'b0);
    if (c128) send_sym(bcr_pkg::BCR_SC_FUNC, 8'h00, 1'b0);
    for (int i = 0; i < d.len(); i++) begin
      send_sym(bcr_pkg::BCR_SC_DATA, d[i], 1'b0);
      e.push_back('{1'b1, d[i], 1'b0});
      if (c128) send_sym(bcr_pkg::BCR_SC_SHIFT, 8'h00, 1'b0);
    end
    if (c128) send_sym(bcr_pkg::BCR_SC_CODESEL, 8'h00, 1'b0);
    send_sym(bcr_pkg::BCR_SC_CHECK, 8'h00, 1'b0);
    send_sym(bcr_pkg::BCR_SC_STARTSTOP, 8'h00, 1'b1);
    e.push_back('{1'b0, 8'h00, 1'b1});
    #5;
    sym_valid = 1'b0;
    `CHK(res_valid, 1'b1)
    `CHK(res_len_ok, len_e)
    `CHK(res_match, match_e)
    chk_tx(e);
  endtask : frame

  task automatic t_preset();
    string s;
    s = "";
    repeat (32) s = {s, "5"};
    send_preset("1\\!\\?\\\\", 1'b1);
    send_preset("0!?", 1'b1);
    send_preset("1/", 1'b0);
    send_preset("\\A", 1'b0);
    send_preset("A\\", 1'b0);
    send_preset(s, 1'b1);
    send_preset({s, "5"}, 1'b0);
    cfg.start_cs = bcr_pkg::BCR_CS_C;
    send_preset({s, s}, 1'b1);
    send_preset({s, s, "5"}, 1'b0);
  endtask : t_preset

  task automatic t_symbols();
    cfg = '{bcr_pkg::BCR_SYM_C128, bcr_pkg::BCR_CS_A, 7'h02};
    cs = bcr_pkg::BCR_CS_A;
    send_preset("A?", 1'b1);
    frame("A\015", 1'b1, 1'b1);
    send_preset("A\\!", 1'b1);
    frame("A\015", 1'b1, 1'b0);
    cfg.digits = 7'h01;
    frame("A\015", 1'b0, 1'b0);
    cfg = '{bcr_pkg::BCR_SYM_C128, bcr_pkg::BCR_CS_C, 7'h03};
    cs = bcr_pkg::BCR_CS_C;
    send_preset("123", 1'b1);
    frame("123", 1'b1, 1'b1);
    cfg.symb = bcr_pkg::BCR_SYM_C93;
    cfg.digits = 7'h02;
    send_preset("X!", 1'b1);
    frame("XY", 1'b1, 1'b1);
  endtask : t_symbols

  task automatic t_stall();
    bcr_pkg::bcr_tx_t e[$];
    cfg.symb = bcr_pkg::BCR_SYM_OTHER;
    stall = 1'b1;
    fork
      for (int i = 0; i < 4; i++) begin
        send_sym(bcr_pkg::BCR_SC_DATA, 8'h41 + 8'(i), i == 3);
        e.push_back('{1'b1, 8'h41 + 8'(i), i == 3});
      end
      begin
        repeat (10) @(posedge core_clk);
        #5;
        `CHK(sym_ready, 1'b0)
        stall = 1'b0;
      end
    join
    #5;
    sym_valid = 1'b0;
    chk_tx(e);
  endtask : t_stall

  task automatic blink(input logic [4:0] pat);
    logic on, off;
    on = 1'b0;
    off = 1'b0;
    repeat (12) begin
      @(negedge core_clk);
      on |= signal_quality_leds === pat;
      off |= signal_quality_leds === 5'h00;
    end
    `CHK({on, off}, 2'b11)
    @(posedge core_clk);
  endtask : blink

  task automatic t_modes();
    #5;
    halt_cmd = 1'b1;
    @(posedge core_clk);
    #5;
    halt_cmd = 1'b0;
    `CHK(laser_en, 1'b0)
    blink(5'h10);
    #5;
    resume_cmd = 1'b1;
    @(posedge core_clk);
    #5;
    resume_cmd = 1'b0;
    `CHK(laser_en, 1'b1)
    test_sw = 1'b1;
    repeat (30) @(posedge core_clk);
    #5;
    test_sw = 1'b0;
    @(posedge core_clk);
    #5;
    test_sw = 1'b1;
    repeat (49) @(posedge core_clk);
    #5;
    `CHK(xfer_wait, 1'b0)
    repeat (3) @(posedge core_clk);
    #5;
    `CHK(xfer_wait, 1'b1)
    `CHK(link_cfg, 19'h411BD)
    blink(5'h15);
    #5;
    test_sw = 1'b0;
    xfer_done = 1'b1;
    @(posedge core_clk);
    #5;
    xfer_done = 1'b0;
    `CHK(xfer_wait, 1'b0)
    @(posedge core_clk);
  endtask : t_modes

  task automatic t_rate();
    int k[3] = '{0, 7, 10};
    foreach (k[j]) begin
      rv_n = 0;
      for (int i = 0; i < 10; i++) begin
        #5;
        scan_end = 1'b1;
        decode_ok = i >= 10 - k[j];
        @(posedge core_clk);
        #5;
        scan_end = 1'b0;
        decode_ok = 1'b0;
        @(posedge core_clk);
      end
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      `CHK(rv_n, 1)
      `CHK(rv_rate, 4'(k[j]))
      @(posedge core_clk);
    end
  endtask : t_rate

  task automatic t_cfg();
    logic [6:0] dg[8] = '{7'h00, 7'h01, 7'h20, 7'h21, 7'h01, 7'h02, 7'h40, 7'h41};
    logic [7:0] bad = 8'h99;
    for (int i = 0; i < 8; i++) begin
      #5;
      cfg = '{bcr_pkg::BCR_SYM_C128, i < 4 ? bcr_pkg::BCR_CS_A : bcr_pkg::BCR_CS_C, dg[i]};
      @(posedge core_clk);
      @(negedge core_clk);
      `CHK(cfg_err, bad[i])
      @(posedge core_clk);
    end
  endtask : t_cfg

  initial begin
    rst = 1'b1;
    {preset_valid, preset_last, sym_valid, halt_cmd, resume_cmd} = '0;
    {test_sw, xfer_done, scan_end, decode_ok, stall} = '0;
    preset_data = 8'h00;
    sym = '0;
    cs = bcr_pkg::BCR_CS_A;
    cfg = '{bcr_pkg::BCR_SYM_C128, bcr_pkg::BCR_CS_A, 7'h02};
    repeat (2) @(posedge core_clk);
    #5;
    rst = 1'b0;
    `CHK(laser_en, 1'b1)
    `CHK(rate, 4'h0)
    @(posedge core_clk);
    t_preset();
    t_symbols();
    t_stall();
    t_modes();
    t_rate();
    t_cfg();
    complete_run();
  end
endmodule : test_bcr_top
